// ===== phgdr_delay_reg.sv
// Clock-enabled delay register with its own optional asynchronous clear.
// Assumes the domain reset is already active high at this port.
`timescale 1ns/100ps
`default_nettype none

module phgdr_delay_reg #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic dom_rst,
    input wire logic local_aclr,
    input wire logic ena,
    input wire logic [WIDTH-1:0] din,
    output var logic [WIDTH-1:0] dout_q
);
    import phgdr_pkg::*;

    // Own clear is merged with the domain reset
    wire logic clr_any;
    assign clr_any = dom_rst | local_aclr;

    // Rising-edge capture, asynchronous clear to zero, hold when disabled
    always_ff @(posedge ref_clk or posedge clr_any) begin
        if (clr_any) begin
            dout_q <= '0;
        end else if (ena) begin
            dout_q <= din;
        end
    end

endmodule : phgdr_delay_reg

`default_nettype wire

// ===== phgdr_pkg.sv
// Constants for the phase gated delay register: register map, fields,
// reset values and bus response codes.
// Assumes one 50 MHz domain clock and a 32-bit AXI4-Lite register bus.
`default_nettype none

package phgdr_pkg;

    // Register byte offsets
    localparam logic [3:0] PHGDR_OFS_PATTERN = 4'h0;
    localparam logic [3:0] PHGDR_OFS_LENGTH = 4'h4;
    localparam logic [3:0] PHGDR_OFS_STATUS = 4'h8;
    localparam logic [3:0] PHGDR_OFS_DATA = 4'hC;

    // Pattern geometry: position i of the string sits in bit i
    localparam int PHGDR_PAT_MAX = 32;
    localparam int PHGDR_POS_W = 5;
    localparam int PHGDR_LEN_W = 6;

    // Field positions inside STATUS
    localparam int PHGDR_ST_POS_LSB = 0;
    localparam int PHGDR_ST_ENA_BIT = 8;

    // Reset values: single position holding a one, always enabled
    localparam logic [31:0] PHGDR_PATTERN_RST = 32'h0000_0001;
    localparam logic [5:0] PHGDR_LENGTH_RST = 6'h01;
    localparam logic [4:0] PHGDR_POS_RST = 5'h00;

    // AXI response codes
    localparam logic [1:0] PHGDR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PHGDR_RESP_DECERR = 2'h3;

    // Clock figure, kept for reference by timing-aware users
    localparam int PHGDR_CLK_PERIOD_NS = 20;

endpackage : phgdr_pkg

`default_nettype wire

// ===== phgdr_properties.sv
// Port checker for the phase gated delay register.
// Assumes one domain clock and an active high reset.
`timescale 1ns/100ps
`default_nettype none
module phgdr_properties #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    input wire logic [WIDTH-1:0] dout,
    input wire logic phase_ena,
    input wire logic ext_ena,
    input wire logic ext_aclr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // One domain, so one clocking and one reset for every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    capture_a: assert property (
        phase_ena && !ext_aclr ##1 !ext_aclr |-> dout == $past(din))
        else $error("dout missed an enabled sample");
    hold_a: assert property (
        !phase_ena && !ext_aclr ##1 !ext_aclr |-> $stable(dout))
        else $error("dout moved while disabled");
    ena_gate_a: assert property (!ext_ena |-> !phase_ena)
        else $error("enable high with external enable low");
    aclr_clear_a: assert property (ext_aclr |-> dout == '0)
        else $error("own clear did not clear dout");
    first_clear_a: assert property ($fell(sys_rst) |-> dout == '0)
        else $error("dout not zero after reset");
    // Both channels taken together: held one cycle, answered the next
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
endmodule : phgdr_properties
bind phgdr_top phgdr_properties #(.WIDTH(WIDTH)) props (.*);
`default_nettype wire

// ===== phgdr_src.sv
// Upstream sample source feeding the delay register.
// Assumes the shared domain clock and reset.
`timescale 1ns/100ps
`default_nettype none
module phgdr_src #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output var logic [WIDTH-1:0] din_q
);
    // Fresh value each slot, so a dropped sample is visible; it moves on
    // the falling edge so it stands still at every rising edge
    always_ff @(negedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            din_q <= '0;
        end else begin
            din_q <= din_q + WIDTH'(1);
        end
    end
endmodule : phgdr_src
`default_nettype wire

// ===== phgdr_top.sv
// Phase gated delay register with AXI4-Lite control.
// A cyclic pattern of enable bits, one position per clock, gates a
// delay register so that slow sample rates ride on one fast clock.
// Assumes upstream logic changes din between rising edges and that the
// domain reset is applied before meaningful operation.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Pattern position advances once per fast clock, wrapping back to the start.
// - Position bit one enables capture; zero makes the register hold.
// - Pattern "1" of length one enables every cycle, passing all samples.
// - Pattern "10" enables alternate cycles, passing every other sample.
// - Pattern "0100" enables only the second cycle of every four.
// - Pattern "100" gives a decimate-by-three shift register starting at zero.
// - The clock domain has its own reset input resetting all its registers.
// - Synthesized clock domains reuse their input clock domain's reset.
// - Every register's reset ties to this domain's top-level reset port.
// - Enable decode is combinational in-slot; data output is registered.
// - All registers update on the rising edge of the domain clock.
// - Registers clear asynchronously from the domain reset.
// - Element's own clear is ORed with the domain reset.
// - Optional external enable and clear; unused they are one and zero.
// - Default domain may use an active-low reset input.
// - Active-low reset pin is inverted so logic sees active high.
module phgdr_top #(
    parameter int WIDTH = 16,
    parameter bit RST_ACTIVE_LOW = 1'b0
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Data path
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout,
    output logic phase_ena,
    // Optional external controls
    input wire logic ext_ena,
    input wire logic ext_aclr,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import phgdr_pkg::*;

    // Domain reset, polarity corrected so everything inside is active high.
    // Any derived domain shares this same reset rather than its own
    wire logic dom_rst;
    assign dom_rst = sys_rst ^ RST_ACTIVE_LOW;

    // Control and sequencing state
    logic [31:0] pattern_q;
    logic [PHGDR_LEN_W-1:0] length_q;
    logic [PHGDR_POS_W-1:0] pos_q;
    logic [PHGDR_POS_W-1:0] pos_d;

    // Bus state
    logic aw_held_q;
    logic [3:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Length zero is treated as one; lengths past the maximum clip to it
    wire logic [PHGDR_LEN_W-1:0] len_eff;
    wire logic [PHGDR_POS_W-1:0] last_pos;
    assign len_eff = (length_q == '0) ? PHGDR_LENGTH_RST :
        (length_q > PHGDR_LEN_W'(PHGDR_PAT_MAX)) ?
        PHGDR_LEN_W'(PHGDR_PAT_MAX) : length_q;
    assign last_pos = PHGDR_POS_W'(len_eff - PHGDR_LEN_W'(1));

    // Enable decode in the same slot as the position, no extra latency
    wire logic pat_bit;
    wire logic delay_ena;
    assign pat_bit = pattern_q[pos_q];
    assign delay_ena = pat_bit & ext_ena;
    assign phase_ena = delay_ena;

    // Write channel bookkeeping
    wire logic aw_take;
    wire logic w_take;
    wire logic wr_fire;
    wire logic wr_hit;
    assign aw_take = s_axi_awvalid & ~aw_held_q & ~bvalid_q;
    assign w_take = s_axi_wvalid & ~w_held_q & ~bvalid_q;
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_hit = (aw_addr_q == PHGDR_OFS_PATTERN) |
        (aw_addr_q == PHGDR_OFS_LENGTH);

    // Byte-lane merge for the pattern register
    wire logic [31:0] pattern_wr;
    wire logic [7:0] length_wr;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign pattern_wr[gb*8 +: 8] = w_strb_q[gb] ?
                w_data_q[gb*8 +: 8] : pattern_q[gb*8 +: 8];
        end
    endgenerate
    assign length_wr = w_strb_q[0] ? w_data_q[7:0] :
        {2'h0, length_q};

    wire logic pat_wr_en;
    wire logic len_wr_en;
    assign pat_wr_en = wr_fire & (aw_addr_q == PHGDR_OFS_PATTERN);
    assign len_wr_en = wr_fire & (aw_addr_q == PHGDR_OFS_LENGTH);

    // Position walks the pattern and wraps; reprogramming restarts it
    assign pos_d = (pat_wr_en | len_wr_en) ? PHGDR_POS_RST :
        (pos_q >= last_pos) ? PHGDR_POS_RST :
        PHGDR_POS_W'(pos_q + PHGDR_POS_W'(1));

    always_ff @(posedge ref_clk or posedge dom_rst) begin
        if (dom_rst) begin
            pos_q <= PHGDR_POS_RST;
        end else begin
            pos_q <= pos_d;
        end
    end

    // Pattern and length hold the enable program
    always_ff @(posedge ref_clk or posedge dom_rst) begin
        if (dom_rst) begin
            pattern_q <= PHGDR_PATTERN_RST;
            length_q <= PHGDR_LENGTH_RST;
        end else begin
            if (pat_wr_en) begin
                pattern_q <= pattern_wr;
            end
            if (len_wr_en) begin
                length_q <= length_wr[PHGDR_LEN_W-1:0];
            end
        end
    end

    // The gated delay itself, reset zero so decimation starts from zero
    phgdr_delay_reg #(
        .WIDTH(WIDTH)
    ) u_delay (
        .ref_clk(ref_clk),
        .dom_rst(dom_rst),
        .local_aclr(ext_aclr),
        .ena(delay_ena),
        .din(din),
        .dout_q(dout)
    );

    // Write address and data are caught separately, in either order
    always_ff @(posedge ref_clk or posedge dom_rst) begin
        if (dom_rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only offsets answer DECERR
    always_ff @(posedge ref_clk or posedge dom_rst) begin
        if (dom_rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= PHGDR_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? PHGDR_RESP_OKAY : PHGDR_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Read decode; status shows the live position and pattern bit, before ext_ena gating
    wire logic [31:0] status_word;
    wire logic [31:0] data_word;
    wire logic [31:0] rd_word;
    wire logic rd_hit;
    assign status_word = (32'(pos_q) << PHGDR_ST_POS_LSB) |
        (32'(pat_bit) << PHGDR_ST_ENA_BIT);
    assign data_word = 32'(dout);
    assign rd_hit = (s_axi_araddr == PHGDR_OFS_PATTERN) |
        (s_axi_araddr == PHGDR_OFS_LENGTH) |
        (s_axi_araddr == PHGDR_OFS_STATUS) |
        (s_axi_araddr == PHGDR_OFS_DATA);
    assign rd_word =
        (s_axi_araddr == PHGDR_OFS_PATTERN) ? pattern_q :
        (s_axi_araddr == PHGDR_OFS_LENGTH) ? 32'(length_q) :
        (s_axi_araddr == PHGDR_OFS_STATUS) ? status_word :
        (s_axi_araddr == PHGDR_OFS_DATA) ? data_word : 32'h0000_0000;

    // One read in flight; address is refused while the answer waits
    assign s_axi_arready = ~rvalid_q;
    always_ff @(posedge ref_clk or posedge dom_rst) begin
        if (dom_rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PHGDR_RESP_OKAY;
        end else if (s_axi_arvalid & ~rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? PHGDR_RESP_OKAY : PHGDR_RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : phgdr_top

`default_nettype wire

// ===== phgdr_top_tb.sv
// Self-checking bench for the phase gated delay register.
// Assumes the register map and bus timing of the top module.
`timescale 1ns/100ps
`default_nettype none
module phgdr_top_tb;
    import phgdr_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, ext_ena = 1'b0, ext_aclr = 1'b0;
    logic [15:0] din, dout, exp_q;
    logic phase_ena, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int failures = 0, n_tests = 0;
    phgdr_src src (.ref_clk(ref_clk), .sys_rst(sys_rst), .din_q(din));
    phgdr_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(din),
        .dout(dout), .phase_ena(phase_ena), .ext_ena(ext_ena),
        .ext_aclr(ext_aclr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    always #10 ref_clk = ~ref_clk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task summarize;
        $display("Checks %0d, failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    // Bus tasks hold each channel until its own ready is seen
    // Handshakes are judged mid-cycle, before the edge that takes them,
    // because ready drops in the very step of the accepting edge
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_seen, w_seen, b_seen;
        logic [1:0] resp;
        b_seen = 1'b0;
        resp = 2'h0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            aw_seen = awvalid & awready;
            w_seen = wvalid & wready;
            b_seen = bvalid;
            resp = bresp;
            @(posedge ref_clk);
            if (aw_seen) awvalid <= 1'b0;
            if (w_seen) wvalid <= 1'b0;
        end while (!b_seen);
        bready <= 1'b0;
        chk({30'h0, resp}, {30'h0, r});
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ar_seen, r_seen;
        logic [31:0] data;
        logic [1:0] resp;
        r_seen = 1'b0;
        data = 32'h0000_0000;
        resp = 2'h0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ar_seen = arvalid & arready;
            r_seen = rvalid;
            data = rdata;
            resp = rresp;
            @(posedge ref_clk);
            if (ar_seen) arvalid <= 1'b0;
        end while (!r_seen);
        rready <= 1'b0;
        chk(data, d);
        chk({30'h0, resp}, {30'h0, r});
    endtask : rd
    // Clear dout first so the model starts from a known zero; the
    // pattern phase is found from its single one, then tracked
    task run_pat(input logic [31:0] pat, input int len, input int one);
        int k;
        logic bit_e;
        wr(PHGDR_OFS_PATTERN, pat, PHGDR_RESP_OKAY);
        wr(PHGDR_OFS_LENGTH, len, PHGDR_RESP_OKAY);
        @(posedge ref_clk);
        ext_aclr <= 1'b1;
        @(posedge ref_clk);
        ext_aclr <= 1'b0;
        exp_q = '0;
        k = 0;
        @(negedge ref_clk);
        while (!phase_ena && k < 40) begin
            @(negedge ref_clk);
            k++;
        end
        for (k = 0; k < 3 * len; k++) begin
            bit_e = pat[(one + k) % len];
            chk({31'h0, phase_ena}, {31'h0, bit_e});
            chk({16'h0, dout}, {16'h0, exp_q});
            // Sample taken where the design takes it, at the rising edge
            @(posedge ref_clk);
            if (bit_e) exp_q = din;
            @(negedge ref_clk);
        end
    endtask : run_pat
    // Reset is held before any traffic; external enable stays low at first
    // so the data read right after reset still shows the cleared delay
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(PHGDR_OFS_PATTERN, PHGDR_PATTERN_RST,
            PHGDR_RESP_OKAY);
        rd(PHGDR_OFS_DATA, 32'h0, PHGDR_RESP_OKAY);
        wr(PHGDR_OFS_STATUS, 32'h3, PHGDR_RESP_DECERR);
        ext_ena <= 1'b1;
        // Every rate below divides the clock rate exactly
        run_pat(32'h1, 1, 0);
        run_pat(32'h1, 2, 0);
        run_pat(32'h2, 4, 1);
        run_pat(32'h1, 3, 0);
        @(posedge ref_clk);
        ext_ena <= 1'b0;
        @(negedge ref_clk);
        chk({31'h0, phase_ena}, 32'h0);
        @(posedge ref_clk);
        ext_ena <= 1'b1;
        // Leave a non-reset program behind so the reset has work to do
        wr(PHGDR_OFS_PATTERN, 32'h5, PHGDR_RESP_OKAY);
        // Reset lands just after a rising edge and must not wait for the next one
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        #5 chk({16'h0, dout}, 32'h0);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(PHGDR_OFS_PATTERN, PHGDR_PATTERN_RST,
            PHGDR_RESP_OKAY);
        rd(PHGDR_OFS_LENGTH, {26'h0, PHGDR_LENGTH_RST},
            PHGDR_RESP_OKAY);
        summarize();
    end
    // Whole run is well under this span
    initial begin
        repeat (3000) @(posedge ref_clk);
        failures++;
        summarize();
    end
endmodule : phgdr_top_tb
`default_nettype wire
